// >>> rtl/sertx_device.sv
// Purpose: asynchronous serial transmitter: holding buffer, shift register, baud generator
// Assumes: configuration is stable while a frame is on the line
// Notes: one stop bit per character; no parity hardware
//   Holding buffer and shift register form a two-deep queue: one character on
//   the line and one waiting. A write while the buffer is full replaces the
//   waiting character, so software checks the buffer-empty flag first.
//   A waiting character moves to the shifter only on an instruction-cycle
//   boundary, so frames are separated by one to four clocks of idle mark.
//   Changing divisor or multiplier selects mid-frame stretches or cuts the bit
//   in flight; software reconfigures only while shift-empty is set.
//   Configuration is read live, not latched per frame, to keep the shifter small.
//   Polarity inversion sits at the pin only, so counters and shifter always work
//   in mark/space terms whatever the line sense.
//   With the port disabled the pin and its enable come straight from the
//   general-purpose side; transmitter state has no effect on it.
// Behaviour
// - Async transmit needs enable, async mode, port enable
// - Port enable makes pin a driven output
// - Software clears analog select before using pin
// - Buffer-empty flag rises when transmit enabled
// - Buffer write starts transmission, loads idle shifter
// - Pending character waits for stop, one cycle transfer
// - Frame starts right after shift register load
// - Polarity bit zero normal, one inverts line
// - Polarity affects data only in async mode
// - NRZ line idles at mark level
// - Start space, eight/nine data, mark stop
// - Each bit lasts one baud period
// - Data least significant bit first
// - Baud generator selectable eight or sixteen bit
// - No hardware parity; ninth bit carries it
// - Disabled transmitter leaves pin to general I/O; here only port enable off does, with port on the pin is driven at mark
// - Shift register loaded only from holding buffer
// - Buffer-empty flag read-only, valid two cycles later
// - Shift-empty set while empty, clear while shifting
// - Nine-bit mode sends ninth bit last
//
// Our own choices: strobed register access and the address map.
`default_nettype none
module sertx_device
    import sertx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link to controller and pin
    sertx_if.device bus,
    // General-purpose pin side when the port is off
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic gpio_in
);
    // Whole device state in one record; nxt is its next-cycle image
    // Line holds the level before polarity, always in mark/space terms
    typedef struct packed {
        tx_state_t state;
        logic [1:0] tcy;
        logic [15:0] brg;
        logic [5:0] mult;
        logic [3:0] bit_idx;
        logic [8:0] shifter;
        logic [8:0] hold;
        logic hold_full;
        logic line;
    } dev_t;

    // Current and next state; cur is the only storage in this module, nxt is combinational
    // Decoded mode, divisor and pacing ticks follow
    dev_t cur;
    dev_t nxt;
    logic active;
    logic [15:0] divisor;
    logic [5:0] mult_last;
    logic bit_tick;
    logic tcy_tick;

    ////////////////////////////////////////////////////////////////////////
    // Mode and baud selection
    // Any of the three controls out of place idles the transmitter
    assign active = bus.transmit_enable && !bus.sync_select && bus.serial_port_enable;
    // Eight-bit generator ignores the high divisor byte
    assign divisor = bus.wide_generator_select ? {bus.baud_divisor_high, bus.baud_divisor_low}
                                               : {8'h00, bus.baud_divisor_low};
    // Multiplier per generator step: both selects 4, either one 16, neither 64
    always_comb begin
        if (bus.high_speed_baud_select && bus.wide_generator_select) begin
            mult_last = MULT4_LAST;
        end else if (bus.high_speed_baud_select || bus.wide_generator_select) begin
            mult_last = MULT16_LAST;
        end else begin
            mult_last = MULT64_LAST;
        end
    end
    assign bit_tick = (cur.mult == mult_last) && (cur.brg == divisor);
    // Free-running four-clock counter paces buffer-to-shifter transfers
    assign tcy_tick = (cur.tcy == TCY_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt = cur;
        nxt.tcy = cur.tcy + 2'h1;
        // Holding buffer written only through the port; shifter has no software path
        // A write with the transmitter inactive is dropped; nothing could send it
        if (bus.hold_write && active) begin
            nxt.hold = {bus.ninth_tx_bit, bus.hold_data};
            nxt.hold_full = 1'b1;
        end
        // Baud counters run only inside a frame. mult counts clocks within one
        // generator step and brg counts steps, so a bit lasts
        // (divisor + 1) * (mult_last + 1) clocks with no divider hardware.
        // Both restart at every bit boundary so bit lengths never drift.
        if (cur.state != TX_IDLE) begin
            if (bit_tick) begin
                nxt.brg = 16'h0000;
                nxt.mult = 6'h00;
            end else if (cur.mult == mult_last) begin
                nxt.mult = 6'h00;
                nxt.brg = cur.brg + 16'h0001;
            end else begin
                nxt.mult = cur.mult + 6'h01;
            end
        end
        case (cur.state)
            TX_IDLE: begin
                // Line rests at mark; reload waits for a held character
                nxt.line = LINE_MARK;
                // Transfer on an instruction-cycle boundary
                if (cur.hold_full && tcy_tick && active) begin
                    nxt.shifter = cur.hold;
                    nxt.hold_full = bus.hold_write;
                    nxt.state = TX_START;
                    nxt.line = LINE_SPACE;
                    nxt.brg = 16'h0000;
                    nxt.mult = 6'h00;
                end
            end
            TX_START: begin
                // Start bit stands one full period, then data bit zero
                if (bit_tick) begin
                    nxt.state = TX_DATA;
                    nxt.bit_idx = 4'h0;
                    nxt.line = cur.shifter[0];
                end
            end
            TX_DATA: begin
                // Ninth bit only in nine-bit mode; it goes out last
                if (bit_tick) begin
                    if (cur.bit_idx == (bus.nine_bit_tx_enable ? DATA9_LAST : DATA8_LAST)) begin
                        nxt.state = TX_STOP;
                        nxt.line = LINE_MARK;
                    end else begin
                        nxt.bit_idx = cur.bit_idx + 4'h1;
                        // Shift right so the next bit always sits at position one
                        nxt.shifter = {1'b0, cur.shifter[8:1]};
                        nxt.line = cur.shifter[1];
                    end
                end
            end
            TX_STOP: begin
                // Stop bit stands one period; idle branch then reloads if a character waits
                if (bit_tick) begin
                    nxt.state = TX_IDLE;
                end
            end
            default: nxt.state = TX_IDLE;
        endcase
        // Dropping the enable aborts the frame and flushes both buffers
        // A cut frame leaves no half character queued; the far receiver sees
        // a long mark and at worst reports a framing error.
        if (!active) begin
            nxt.state = TX_IDLE;
            nxt.hold_full = 1'b0;
            nxt.line = LINE_MARK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    // Reset parks the line at mark so the pin shows idle once the port is on
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{state: TX_IDLE, tcy: 2'h0, brg: 16'h0000, mult: 6'h00, bit_idx: 4'h0,
                     shifter: 9'h000, hold: 9'h000, hold_full: 1'b0, line: LINE_MARK};
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and pin
    // Buffer flag is combinational from the registered full bit. The write
    // pulse is itself registered in the controller, so the flag settles in
    // the second cycle after the software write; polling earlier misleads.
    // Shift-empty covers start, data and stop bits: it falls at load and
    // rises after the stop bit has stood its full period, or on the next edge if a frame is aborted.
    // Neither status raises an interrupt; software polls them.
    assign bus.tx_buffer_empty_flag = active && !cur.hold_full;
    assign bus.shift_empty_status = (cur.state == TX_IDLE);
    // Polarity applies only in async mode
    // With the port off, pin level and enable come from the general-purpose side
    assign bus.pin_out = bus.serial_port_enable
                         ? (cur.line ^ (bus.tx_polarity_select && !bus.sync_select))
                         : gpio_out;
    assign bus.pin_oe = bus.serial_port_enable ? 1'b1 : gpio_oe;
    assign gpio_in = bus.pin_in;
endmodule : sertx_device
`default_nettype wire

// >>> inc/sertx_pkg.sv
// Purpose: shared constants and types for the asynchronous serial transmitter pair
// Assumes: one 250 MHz system clock; instruction cycle is four clocks
// Notes: register offsets belong to the controller's own command port
`default_nettype none
package sertx_pkg;
    // Clock and instruction-cycle pacing
    localparam int unsigned CLK_MHZ = 250;
    localparam logic [1:0] TCY_LAST = 2'h3;
    // Baud multipliers minus one (64, 16, 4)
    localparam logic [5:0] MULT64_LAST = 6'h3F;
    localparam logic [5:0] MULT16_LAST = 6'h0F;
    localparam logic [5:0] MULT4_LAST = 6'h03;
    // Frame layout
    localparam logic [3:0] DATA8_LAST = 4'h7;
    localparam logic [3:0] DATA9_LAST = 4'h8;
    localparam logic LINE_MARK = 1'b1;
    localparam logic LINE_SPACE = 1'b0;
    // Controller register offsets
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DIV_LOW = 4'h1;
    localparam logic [3:0] ADDR_DIV_HIGH = 4'h2;
    localparam logic [3:0] ADDR_DATA = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_GPIO = 4'h5;
    // Control register fields
    localparam int unsigned CTL_TRANSMIT_ENABLE = 0;
    localparam int unsigned CTL_SYNC = 1;
    localparam int unsigned CTL_SERIAL_PORT_ENABLE = 2;
    localparam int unsigned CTL_NINE = 3;
    localparam int unsigned CTL_NINTH = 4;
    localparam int unsigned CTL_POL = 5;
    localparam int unsigned CTL_HIGH_SPEED_BAUD_SELECT = 6;
    localparam int unsigned CTL_WIDE = 7;
    // Transmit states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } tx_state_t;
endpackage : sertx_pkg
`default_nettype wire

// >>> inc/sertx_if.sv
// Purpose: carrier joining the transmitter device and its controller
// Assumes: both ends clocked by sys_clk
// Notes: the pin is three signals (pin_in, pin_out, pin_oe); the bench resolves the wire
`default_nettype none
interface sertx_if;
    import sertx_pkg::*;
    // Configuration from controller
    logic transmit_enable;
    logic sync_select;
    logic serial_port_enable;
    logic nine_bit_tx_enable;
    logic ninth_tx_bit;
    logic tx_polarity_select;
    logic high_speed_baud_select;
    logic wide_generator_select;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    // Holding buffer write
    logic hold_write;
    logic [7:0] hold_data;
    // Status back to controller
    logic tx_buffer_empty_flag;
    logic shift_empty_status;
    // Pin as seen by the device
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    modport device (
        input transmit_enable, sync_select, serial_port_enable, nine_bit_tx_enable, ninth_tx_bit,
        input tx_polarity_select, high_speed_baud_select, wide_generator_select,
        input baud_divisor_low, baud_divisor_high, hold_write, hold_data, pin_in,
        output tx_buffer_empty_flag, shift_empty_status, pin_out, pin_oe
    );
    modport controller (
        output transmit_enable, sync_select, serial_port_enable, nine_bit_tx_enable, ninth_tx_bit,
        output tx_polarity_select, high_speed_baud_select, wide_generator_select,
        output baud_divisor_low, baud_divisor_high, hold_write, hold_data,
        input tx_buffer_empty_flag, shift_empty_status
    );
endinterface : sertx_if
`default_nettype wire

// >>> rtl/sertx_controller.sv
// Purpose: controller end: software registers that drive the transmitter
// Assumes: simple strobe port, read data one cycle after read strobe
// Notes: software must clear analog select itself before enabling the port
`default_nettype none
module sertx_controller
    import sertx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Software port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Analog function sharing the pin
    output logic analog_select,
    // Link to device
    sertx_if.controller bus
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic analog;
        logic wr_pulse;
        logic [7:0] data;
        logic [7:0] rdata;
    } ctl_t;

    ctl_t cur;
    ctl_t nxt;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    always_comb begin
        nxt = cur;
        nxt.wr_pulse = 1'b0;
        nxt.rdata = 8'h00;
        if (wr_en) begin
            if (addr == ADDR_CONTROL) begin
                nxt.control = wdata;
            end else if (addr == ADDR_DIV_LOW) begin
                nxt.div_low = wdata;
            end else if (addr == ADDR_DIV_HIGH) begin
                nxt.div_high = wdata;
            end else if (addr == ADDR_DATA) begin
                nxt.data = wdata;
                nxt.wr_pulse = 1'b1;
            end else if (addr == ADDR_GPIO) begin
                nxt.analog = wdata[0];
            end
        end
        if (rd_en) begin
            if (addr == ADDR_CONTROL) begin
                nxt.rdata = cur.control;
            end else if (addr == ADDR_DIV_LOW) begin
                nxt.rdata = cur.div_low;
            end else if (addr == ADDR_DIV_HIGH) begin
                nxt.rdata = cur.div_high;
            end else if (addr == ADDR_STATUS) begin
                nxt.rdata = {6'h00, bus.shift_empty_status, bus.tx_buffer_empty_flag};
            end else if (addr == ADDR_GPIO) begin
                nxt.rdata = {7'h00, cur.analog};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; polarity resets to zero, analog select to one (analog on)
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{control: 8'h00, div_low: 8'h00, div_high: 8'h00, analog: 1'b1,
                     wr_pulse: 1'b0, data: 8'h00, rdata: 8'h00};
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs toward software, analog function and device
    assign rdata = cur.rdata;
    assign analog_select = cur.analog;
    assign bus.transmit_enable = cur.control[CTL_TRANSMIT_ENABLE];
    assign bus.sync_select = cur.control[CTL_SYNC];
    assign bus.serial_port_enable = cur.control[CTL_SERIAL_PORT_ENABLE];
    assign bus.nine_bit_tx_enable = cur.control[CTL_NINE];
    assign bus.ninth_tx_bit = cur.control[CTL_NINTH];
    assign bus.tx_polarity_select = cur.control[CTL_POL];
    assign bus.high_speed_baud_select = cur.control[CTL_HIGH_SPEED_BAUD_SELECT];
    assign bus.wide_generator_select = cur.control[CTL_WIDE];
    assign bus.baud_divisor_low = cur.div_low;
    assign bus.baud_divisor_high = cur.div_high;
    assign bus.hold_write = cur.wr_pulse;
    assign bus.hold_data = cur.data;
endmodule : sertx_controller
`default_nettype wire

// >>> tb/sertx_assertions.sv
// Purpose: property checks on the link between controller and transmitter
// Assumes: single clock domain, reset active low
// Notes: frame length judged by a busy-cycle counter
`default_nettype none
module sertx_assertions
    import sertx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic transmit_enable,
    input wire logic sync_select,
    input wire logic serial_port_enable,
    input wire logic nine_bit_tx_enable,
    input wire logic tx_polarity_select,
    input wire logic high_speed_baud_select,
    input wire logic wide_generator_select,
    input wire logic [7:0] baud_divisor_low,
    input wire logic [7:0] baud_divisor_high,
    // Transfer, status and pin
    input wire logic hold_write,
    input wire logic tx_buffer_empty_flag,
    input wire logic shift_empty_status,
    input wire logic pin_out,
    input wire logic pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic active;
    logic [31:0] period;
    logic [31:0] busy_cnt;
    ////////////////////////////////////////////////////////////
    // Bit period; high divisor byte counts only with the wide generator
    assign active = transmit_enable && !sync_select && serial_port_enable;
    assign period = ({16'h0000, wide_generator_select ? baud_divisor_high : 8'h00, baud_divisor_low} + 32'h1)
        << (high_speed_baud_select ? (wide_generator_select ? 2 : 4) : (wide_generator_select ? 4 : 6));
    // Cleared on every idle cycle so a stuck shifter also shows
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= shift_empty_status ? 32'h0 : busy_cnt + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    idle_mark_a:
        assert property (active && shift_empty_status |-> pin_out == (LINE_MARK ^ tx_polarity_select))
        else $error("line not at idle mark");
    port_drive_a:
        assert property (serial_port_enable |-> pin_oe) else $error("pin not driven with port on");
    flag_inactive_a:
        assert property (!active |-> !tx_buffer_empty_flag) else $error("buffer flag set while inactive");
    flag_enable_a:
        assert property ($rose(transmit_enable) && !sync_select && serial_port_enable |-> tx_buffer_empty_flag)
        else $error("buffer flag not set on enable");
    start_space_a:
        assert property ($fell(shift_empty_status) && active |-> pin_out == (LINE_SPACE ^ tx_polarity_select))
        else $error("no start bit at load");
    write_load_a:
        assert property (hold_write && active && shift_empty_status |-> ##[1:5] !shift_empty_status)
        else $error("write to idle shifter not loaded");
    write_held_a:
        assert property (hold_write && active && !shift_empty_status |=> !tx_buffer_empty_flag)
        else $error("pending character not held");
    pending_load_a:
        assert property (active && shift_empty_status && !tx_buffer_empty_flag |-> ##[1:4] !shift_empty_status)
        else $error("pending character not loaded in time");
    frame_len_a:
        assert property ($rose(shift_empty_status) && active
            |-> busy_cnt == period * (nine_bit_tx_enable ? 32'h0000000B : 32'h0000000A))
        else $error("frame length wrong");
endmodule : sertx_assertions
`default_nettype wire

// >>> tb/async_serial_transmitter_tb.sv
// Purpose: self-checking bench for controller and transmitter
// Assumes: 250 MHz clock, pull-up on the pin
// Notes: line monitor samples each frame at mid-bit
`default_nettype none
module async_serial_transmitter_tb
    import sertx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    logic analog_select;
    logic gpio_out = 1'b0;
    logic gpio_oe = 1'b0;
    logic gpio_in;
    logic [7:0] ctl = 8'h00;
    int bp = 16;
    int nb = 8;
    int fail_count = 0;
    int checks = 0;
    logic [8:0] exp_q[$];
    logic [7:0] rexp_q[$];
    sertx_if bus ();
    ////////////////////////////////////////////////////////////
    always #2 sys_clk = ~sys_clk;
    // Wire level: pull-up when nobody drives
    assign bus.pin_in = bus.pin_oe ? bus.pin_out : 1'b1;
    sertx_device sertx_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.device), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_in(gpio_in));
    sertx_controller sertx_controller_i (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .analog_select(analog_select), .bus(bus.controller));
    sertx_assertions sertx_assertions_i (.sys_clk(sys_clk), .rst_n(rst_n), .transmit_enable(bus.transmit_enable),
        .sync_select(bus.sync_select), .serial_port_enable(bus.serial_port_enable),
        .nine_bit_tx_enable(bus.nine_bit_tx_enable), .tx_polarity_select(bus.tx_polarity_select),
        .high_speed_baud_select(bus.high_speed_baud_select), .wide_generator_select(bus.wide_generator_select),
        .baud_divisor_low(bus.baud_divisor_low), .baud_divisor_high(bus.baud_divisor_high),
        .hold_write(bus.hold_write), .tx_buffer_empty_flag(bus.tx_buffer_empty_flag),
        .shift_empty_status(bus.shift_empty_status), .pin_out(bus.pin_out), .pin_oe(bus.pin_oe));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr
    // One-cycle read strobe; the expected value is queued before it goes out
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rexp_q.push_back(e);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
    endtask : rd
    // Bounded wait: 0 shifter busy, 1 buffer free, 2 all sent
    task automatic await(input int k);
        int n;
        for (n = 0; n < 60000; n++) begin
            @(negedge sys_clk);
            if (k == 0 && bus.shift_empty_status === 1'b0) break;
            if (k == 1 && bus.tx_buffer_empty_flag === 1'b1) break;
            if (k == 2 && exp_q.size() == 0 && bus.shift_empty_status === 1'b1) break;
        end
        check(16'(n == 60000), 16'h0);
    endtask : await
    // Monitor goes blind until the new control value has settled
    task automatic mode(input logic [7:0] c, input logic [7:0] dl, input logic [7:0] dh, input int b);
        ctl = 8'h00;
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_DIV_LOW, dl);
        wr(ADDR_DIV_HIGH, dh);
        wr(ADDR_CONTROL, c);
        repeat (2) @(posedge sys_clk);
        ctl = c;
        bp = b;
        nb = c[CTL_NINE] ? 9 : 8;
        check({15'h0, bus.tx_buffer_empty_flag}, 16'h1);
        rd(ADDR_CONTROL, c);
        rd(ADDR_STATUS, 8'h03);
    endtask : mode
    // Ninth bit goes in before the low byte
    task automatic send(input logic [8:0] v);
        exp_q.push_back(nb == 9 ? v : {1'b0, v[7:0]});
        if (nb == 9) wr(ADDR_CONTROL, ctl | {3'h0, v[8], 4'h0});
        wr(ADDR_DATA, v[7:0]);
    endtask : send
    ////////////////////////////////////////////////////////////
    // Read data land one cycle after the strobe
    always @(posedge sys_clk) begin
        rd_q <= rd_en;
        if (rd_q) check({8'h00, rdata}, {8'h00, rexp_q.pop_front()});
    end
    // Line monitor: start edge, then mid-bit samples
    initial begin
        logic [8:0] got;
        forever begin
            @(posedge sys_clk);
            if (ctl[0] && !ctl[1] && ctl[2] && bus.pin_in === (LINE_SPACE ^ ctl[CTL_POL])) begin
                got = 9'h000;
                repeat (bp / 2) @(posedge sys_clk);
                check({15'h0, bus.pin_in ^ ctl[CTL_POL]}, {15'h0, LINE_SPACE});
                for (int i = 0; i < nb; i++) begin
                    repeat (bp) @(posedge sys_clk);
                    got[i] = bus.pin_in ^ ctl[CTL_POL];
                end
                repeat (bp) @(posedge sys_clk);
                check({15'h0, bus.pin_in ^ ctl[CTL_POL]}, {15'h0, LINE_MARK});
                check({7'h00, got}, {7'h00, exp_q.pop_front()});
            end
        end
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        static logic [7:0] c_t [6] = '{8'hC5, 8'h45, 8'h85, 8'h05, 8'hC5, 8'hED};
        static logic [7:0] l_t [6] = '{8'h03, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
        static logic [7:0] h_t [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
        static int b_t [6] = '{16, 32, 32, 64, 1028, 8};
        int seed;
        seed = $urandom(32'h5A0A);
        repeat (3) @(posedge sys_clk);
        check({15'h0, bus.shift_empty_status}, 16'h1);
        check({14'h0, bus.tx_buffer_empty_flag, analog_select}, 16'h1);
        rst_n <= 1'b1;
        // Port off: pin belongs to general I/O
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            gpio_out <= 1'($urandom);
            gpio_oe <= 1'($urandom);
            @(negedge sys_clk);
            check({15'h0, gpio_in}, {15'h0, gpio_oe ? gpio_out : 1'b1});
        end
        gpio_oe <= 1'b0;
        wr(ADDR_GPIO, 8'h00);
        // Register lands at the strobe's edge; look once it has settled
        @(negedge sys_clk);
        check({15'h0, analog_select}, 16'h0);
        rd(4'h9, 8'h00);
        // Data while port on but transmitter off is dropped
        wr(ADDR_CONTROL, 8'h04);
        wr(ADDR_DATA, 8'(seed));
        rd(ADDR_STATUS, 8'h02);
        for (int m = 0; m < 6; m++) begin
            mode(c_t[m], l_t[m], h_t[m], b_t[m]);
            if (m == 0) begin
                repeat (8) @(posedge sys_clk);
                check({15'h0, bus.shift_empty_status}, 16'h1);
                send(9'($urandom));
                await(0);
                send(9'($urandom));
                @(posedge sys_clk);
                @(negedge sys_clk);
                check({15'h0, bus.tx_buffer_empty_flag}, 16'h0);
                rd(ADDR_STATUS, 8'h00);
                await(1);
            end
            send(9'($urandom));
            await(2);
            if (m == 5) begin
                send(9'($urandom) | 9'h100);
                await(2);
            end
        end
        repeat (8) @(posedge sys_clk);
        close_out();
    end
endmodule : async_serial_transmitter_tb
`default_nettype wire
